// ===== hw/obm_byte_move_core.sv
// Byte transfer and exchange execution core with operand decode
`timescale 1ns/10ps
`default_nettype none
module obm_byte_move_core (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic instValid,
	input wire obm_pkg::obm_op_t instOp,
	input wire obm_pkg::obm_opnd_t instOperand,
	input wire logic [2:0] instReg,
	input wire logic [1:0] instPair,
	input wire logic [7:0] instImm,
	input wire logic [15:0] instAddr,
	input wire logic [15:0] instPc,
	input wire logic fetchFromRom,
	input wire logic resZero,
	input wire logic resHalfCarry,
	input wire logic resCarry,
	input wire logic [7:0] savedPsw,
	input wire logic [2:0] processorClockCtrl,
	input wire logic [7:0] memRdata,
	input wire logic memRvalid,
	output logic instBusy,
	output logic instDone,
	output logic operandFault,
	output logic [15:0] decodedAddr,
	output logic [7:0] bitMask,
	output logic [5:0] instClocks,
	output logic [7:0] accumulator,
	output logic [7:0] programStatusWord,
	output logic memReq,
	output logic memWe,
	output logic [15:0] memAddr,
	output logic [7:0] memWdata
);
	// ----------------------------------------
	// State and latched instruction
	// ----------------------------------------
	typedef enum {ST_IDLE, ST_EXEC, ST_READ, ST_COUNT} obm_state_t;
	obm_state_t state_reg, state_next;
	obm_pkg::obm_op_t op_reg;
	obm_pkg::obm_opnd_t opnd_reg;
	logic [2:0] rIdx_reg;
	logic [1:0] pIdx_reg;
	logic [7:0] imm_reg;
	logic [15:0] addr_reg;
	logic [15:0] pc_reg;
	logic rom_reg;
	logic [2:0] res_reg;
	logic [7:0] saved_reg;
	logic [obm_pkg::CW-1:0] cnt_reg, target_reg;
	logic [3:0] divCnt_reg;
	logic busy_reg, done_reg, fault_reg;
	logic [15:0] effAddr_reg;
	logic [7:0] bitMask_reg;
	logic [obm_pkg::CW-1:0] clocks_reg;
	logic [7:0] psw_reg, psw_next;
	logic memReq_reg, memWe_reg;
	logic [15:0] memAddr_reg;
	logic [7:0] memWdata_reg;
	logic [7:0] regFile [obm_pkg::NUM_REGS];
	obm_dec_if decBus ();

	// ----------------------------------------
	// Operand decoder
	// ----------------------------------------
	obm_operand_decode uDecode (
		.bus(decBus)
	);

	// Decoder fed from latched fields and live pointer registers
	assign decBus.opndClass = opnd_reg;
	assign decBus.pairIdx = pIdx_reg;
	assign decBus.imm = imm_reg;
	assign decBus.addrField = addr_reg;
	assign decBus.pc = pc_reg;
	assign decBus.hl = {regFile[obm_pkg::IDX_H], regFile[obm_pkg::IDX_L]};
	assign decBus.de = {regFile[obm_pkg::IDX_D], regFile[obm_pkg::IDX_E]};
	assign decBus.regB = regFile[obm_pkg::IDX_B];
	assign decBus.regC = regFile[obm_pkg::IDX_C];

	// ----------------------------------------
	// Operation classes
	// ----------------------------------------
	wire logic start = instValid && !busy_reg;
	wire logic isXch = (op_reg == obm_pkg::OP_XCH_A_M) || (op_reg == obm_pkg::OP_XCH_A_R);
	wire logic memRead = (op_reg == obm_pkg::OP_MOV_A_M) || (op_reg == obm_pkg::OP_XCH_A_M);
	wire logic memStore = (op_reg == obm_pkg::OP_MOV_M_A) || (op_reg == obm_pkg::OP_MOV_M_IMM);
	wire logic memOp = memRead || memStore;
	wire logic sfrClass = (opnd_reg == obm_pkg::OPND_SFR) || (opnd_reg == obm_pkg::OPND_SFRP);
	wire logic hlRegClass = (opnd_reg == obm_pkg::OPND_HLB) || (opnd_reg == obm_pkg::OPND_HLC);
	wire logic [7:0] accVal = regFile[obm_pkg::IDX_A];
	wire logic [7:0] regVal = regFile[rIdx_reg];
	wire logic execOk = (state_reg == ST_EXEC) && !decBus.fault;

	// ----------------------------------------
	// Clock accounting
	// ----------------------------------------
	// Base count of the memory forms; sfr counts are already the long figure
	logic [obm_pkg::CW-1:0] memBase, shortCnt, longAdd, targetCnt;
	always_comb begin
		case (opnd_reg)
			obm_pkg::OPND_SADDR: memBase = obm_pkg::CLK_SADDR;
			obm_pkg::OPND_SFR: memBase = isXch ? obm_pkg::CLK_SFR_XCH : obm_pkg::CLK_SFR_MOV;
			obm_pkg::OPND_ABS: memBase = obm_pkg::CLK_ABS;
			obm_pkg::OPND_DE: memBase = obm_pkg::CLK_IND;
			obm_pkg::OPND_HL: memBase = obm_pkg::CLK_IND;
			obm_pkg::OPND_HLBYTE: memBase = obm_pkg::CLK_HLBYTE;
			default: memBase = (hlRegClass && isXch) ? obm_pkg::CLK_HLBYTE : obm_pkg::CLK_HLREG;
		endcase
	end

	// Short count per operation
	always_comb begin
		case (op_reg)
			obm_pkg::OP_MOV_R_IMM: shortCnt = obm_pkg::CLK_R_IMM;
			obm_pkg::OP_MOV_M_IMM: shortCnt = sfrClass ? obm_pkg::CLK_SFR_IMM : obm_pkg::CLK_SADDR_IMM;
			obm_pkg::OP_MOV_PSW_IMM: shortCnt = obm_pkg::CLK_SFR_IMM;
			obm_pkg::OP_MOV_A_PSW: shortCnt = obm_pkg::CLK_SFR_MOV;
			obm_pkg::OP_MOV_PSW_A: shortCnt = obm_pkg::CLK_SFR_MOV;
			obm_pkg::OP_MOV_A_M: shortCnt = memBase;
			obm_pkg::OP_MOV_M_A: shortCnt = memBase;
			obm_pkg::OP_XCH_A_M: shortCnt = memBase;
			default: shortCnt = obm_pkg::CLK_REG;
		endcase
	end

	// Long count only when a data access leaves the fast RAM
	assign longAdd = (memOp && !sfrClass && !decBus.inHsRam) ?
		(isXch ? obm_pkg::CLK_EXT_XCH : obm_pkg::CLK_EXT_MOV) : {obm_pkg::CW{1'b0}};
	// Fetch outside ROM costs extra; the table figures hold only for ROM
	assign targetCnt = shortCnt + longAdd + (rom_reg ? {obm_pkg::CW{1'b0}} : obm_pkg::FETCH_EXTRA);

	// ----------------------------------------
	// CPU clock divider
	// ----------------------------------------
	// Selected setting is clamped so a bad value cannot stall the count
	wire logic [2:0] pccSel = (processorClockCtrl > obm_pkg::PCC_MAX) ? obm_pkg::PCC_MAX : processorClockCtrl;
	wire logic [3:0] divLimit = 4'((5'h01 << pccSel) - 5'h01);
	wire logic cpuTick = (divCnt_reg == divLimit);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			divCnt_reg <= 4'h0;
		end else begin
			divCnt_reg <= (cpuTick || !busy_reg) ? 4'h0 : divCnt_reg + 4'h1;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	wire logic countDone = (state_reg == ST_COUNT) && (cnt_reg >= target_reg);
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: state_next = start ? ST_EXEC : ST_IDLE;
			ST_EXEC: state_next = decBus.fault ? ST_IDLE : (memRead ? ST_READ : ST_COUNT);
			ST_READ: state_next = memRvalid ? ST_COUNT : ST_READ;
			ST_COUNT: state_next = countDone ? ST_IDLE : ST_COUNT;
			default: state_next = ST_IDLE;
		endcase
	end

	// Instruction latch, taken only while idle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			op_reg <= obm_pkg::OP_DECODE;
			opnd_reg <= obm_pkg::OPND_NONE;
			rIdx_reg <= 3'h0;
			pIdx_reg <= 2'h0;
			imm_reg <= 8'h00;
			addr_reg <= 16'h0000;
			pc_reg <= 16'h0000;
			rom_reg <= 1'b1;
			res_reg <= 3'h0;
			saved_reg <= 8'h00;
		end else if (start) begin
			op_reg <= instOp;
			opnd_reg <= instOperand;
			rIdx_reg <= instReg;
			pIdx_reg <= instPair;
			imm_reg <= instImm;
			addr_reg <= instAddr;
			pc_reg <= instPc;
			rom_reg <= fetchFromRom;
			res_reg <= {resZero, resHalfCarry, resCarry};
			saved_reg <= savedPsw;
		end
	end

	// State, counters and completion flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			fault_reg <= 1'b0;
			cnt_reg <= {obm_pkg::CW{1'b0}};
			target_reg <= {obm_pkg::CW{1'b0}};
			clocks_reg <= {obm_pkg::CW{1'b0}};
		end else begin
			state_reg <= state_next;
			busy_reg <= (state_next != ST_IDLE);
			done_reg <= countDone || ((state_reg == ST_EXEC) && decBus.fault);
			if (start) begin
				cnt_reg <= {obm_pkg::CW{1'b0}};
				fault_reg <= 1'b0;
			end else if (busy_reg && cpuTick) begin
				cnt_reg <= cnt_reg + {{(obm_pkg::CW-1){1'b0}}, 1'b1};
			end
			if (state_reg == ST_EXEC) begin
				fault_reg <= decBus.fault;
				target_reg <= targetCnt;
				clocks_reg <= decBus.fault ? {obm_pkg::CW{1'b0}} : targetCnt;
			end
		end
	end

	// Decoded address and bit mask held for the caller
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			effAddr_reg <= 16'h0000;
			bitMask_reg <= 8'h00;
		end else if (state_reg == ST_EXEC) begin
			effAddr_reg <= decBus.effAddr;
			bitMask_reg <= decBus.bitMask;
		end
	end

	// ----------------------------------------
	// Memory bus
	// ----------------------------------------
	// Exchange writes the old accumulator back in the cycle after the read answer
	wire logic rdBack = (state_reg == ST_READ) && memRvalid;
	wire logic issueRd = execOk && memRead;
	wire logic issueWr = (execOk && memStore) || (rdBack && isXch);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			memReq_reg <= 1'b0;
			memWe_reg <= 1'b0;
			memAddr_reg <= 16'h0000;
			memWdata_reg <= 8'h00;
		end else begin
			memReq_reg <= issueRd || issueWr;
			if (issueRd || issueWr) begin
				memWe_reg <= issueWr;
				memAddr_reg <= decBus.effAddr;
				memWdata_reg <= (op_reg == obm_pkg::OP_MOV_M_IMM) ? imm_reg : accVal;
			end
		end
	end

	// ----------------------------------------
	// Register file writes
	// ----------------------------------------
	// Two ports so an exchange moves both bytes in the same edge
	logic weA, weR;
	logic [7:0] dataA, dataR;
	always_comb begin
		weA = 1'b0;
		weR = 1'b0;
		dataA = accVal;
		dataR = regVal;
		if (execOk) begin
			case (op_reg)
				obm_pkg::OP_MOV_R_IMM: begin
					weR = 1'b1;
					dataR = imm_reg;
				end
				obm_pkg::OP_MOV_A_R: begin
					weA = 1'b1;
					dataA = regVal;
				end
				obm_pkg::OP_MOV_R_A: begin
					weR = 1'b1;
					dataR = accVal;
				end
				obm_pkg::OP_MOV_A_PSW: begin
					weA = 1'b1;
					dataA = psw_reg;
				end
				obm_pkg::OP_XCH_A_R: begin
					weA = 1'b1;
					weR = 1'b1;
					dataA = regVal;
					dataR = accVal;
				end
				default: weA = 1'b0;
			endcase
		end else if (rdBack) begin
			weA = 1'b1;
			dataA = memRdata;
		end
	end

	// One flop group per register; accumulator port wins on a clash
	generate
		for (genvar i = 0; i < obm_pkg::NUM_REGS; i++) begin : gReg
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					regFile[i] <= obm_pkg::REG_RESET;
				end else if (weA && (3'(i) == obm_pkg::IDX_A)) begin
					regFile[i] <= dataA;
				end else if (weR && (3'(i) == rIdx_reg)) begin
					regFile[i] <= dataR;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Program status word
	// ----------------------------------------
	// Plain moves and exchanges fall to the default and keep every flag
	always_comb begin
		psw_next = psw_reg;
		if (execOk) begin
			case (op_reg)
				obm_pkg::OP_MOV_PSW_IMM: psw_next = imm_reg;
				obm_pkg::OP_MOV_PSW_A: psw_next = accVal;
				obm_pkg::OP_FLAG_RESTORE: psw_next = saved_reg;
				obm_pkg::OP_FLAG_RESULT: begin
					psw_next[obm_pkg::PSW_Z] = res_reg[2];
					psw_next[obm_pkg::PSW_AC] = res_reg[1];
					psw_next[obm_pkg::PSW_CY] = res_reg[0];
				end
				default: psw_next = psw_reg;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			psw_reg <= obm_pkg::PSW_RESET;
		end else begin
			psw_reg <= psw_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign instBusy = busy_reg;
	assign instDone = done_reg;
	assign operandFault = fault_reg;
	assign decodedAddr = effAddr_reg;
	assign bitMask = bitMask_reg;
	assign instClocks = clocks_reg;
	assign accumulator = regFile[obm_pkg::IDX_A];
	assign programStatusWord = psw_reg;
	assign memReq = memReq_reg;
	assign memWe = memWe_reg;
	assign memAddr = memAddr_reg;
	assign memWdata = memWdata_reg;
endmodule // obm_byte_move_core
`default_nettype wire

// ===== hw/obm_pkg.sv
// Shared constants and types for the operand decoder and byte-move core
package obm_pkg;
	// ----------------------------------------
	// Address windows
	// ----------------------------------------
	localparam logic [15:0] SADDR_BASE = 16'hFE20;
	localparam logic [15:0] SFR_BASE = 16'hFF00;
	localparam logic [15:0] SFR_HOLE_LO = 16'hFFD0;
	localparam logic [15:0] SFR_HOLE_HI = 16'hFFDF;
	localparam logic [15:0] CALL_BASE = 16'h0800;
	localparam logic [15:0] VEC_BASE = 16'h0040;
	localparam logic [15:0] HSRAM_LO = 16'hFB00;
	localparam logic [15:0] HSRAM_HI = 16'hFEFF;
	// ----------------------------------------
	// Register file and status word layout
	// ----------------------------------------
	localparam logic [2:0] IDX_A = 3'h1;
	localparam logic [2:0] IDX_C = 3'h2;
	localparam logic [2:0] IDX_B = 3'h3;
	localparam logic [2:0] IDX_E = 3'h4;
	localparam logic [2:0] IDX_D = 3'h5;
	localparam logic [2:0] IDX_L = 3'h6;
	localparam logic [2:0] IDX_H = 3'h7;
	localparam int NUM_REGS = 8;
	localparam int PSW_CY = 0;
	localparam int PSW_AC = 4;
	localparam int PSW_Z = 6;
	localparam logic [7:0] PSW_RESET = 8'h02;
	localparam logic [7:0] REG_RESET = 8'h00;
	// ----------------------------------------
	// Instruction clock counts
	// ----------------------------------------
	localparam int CW = 6;
	localparam logic [CW-1:0] CLK_REG = 6'h02;
	localparam logic [CW-1:0] CLK_R_IMM = 6'h04;
	localparam logic [CW-1:0] CLK_SADDR = 6'h04;
	localparam logic [CW-1:0] CLK_SADDR_IMM = 6'h06;
	localparam logic [CW-1:0] CLK_SFR_MOV = 6'h05;
	localparam logic [CW-1:0] CLK_SFR_XCH = 6'h06;
	localparam logic [CW-1:0] CLK_SFR_IMM = 6'h07;
	localparam logic [CW-1:0] CLK_ABS = 6'h08;
	localparam logic [CW-1:0] CLK_IND = 6'h04;
	localparam logic [CW-1:0] CLK_HLBYTE = 6'h08;
	localparam logic [CW-1:0] CLK_HLREG = 6'h06;
	localparam logic [CW-1:0] CLK_EXT_MOV = 6'h01;
	localparam logic [CW-1:0] CLK_EXT_XCH = 6'h02;
	localparam logic [CW-1:0] FETCH_EXTRA = 6'h02;
	localparam logic [2:0] PCC_MAX = 3'h4;
	// ----------------------------------------
	// Operand classes and operations
	// ----------------------------------------
	typedef enum logic [4:0] {OPND_NONE, OPND_REG, OPND_PAIR, OPND_SADDR, OPND_SADDRP, OPND_SFR,
		OPND_SFRP, OPND_ABS, OPND_ABSW, OPND_DE, OPND_HL, OPND_HLBYTE, OPND_HLB,
		OPND_HLC, OPND_CALL, OPND_VEC, OPND_REL, OPND_BIT} obm_opnd_t;
	typedef enum logic [3:0] {OP_MOV_R_IMM, OP_MOV_M_IMM, OP_MOV_A_R, OP_MOV_R_A, OP_MOV_A_M,
		OP_MOV_M_A, OP_MOV_PSW_IMM, OP_MOV_A_PSW, OP_MOV_PSW_A, OP_XCH_A_R,
		OP_XCH_A_M, OP_FLAG_RESULT, OP_FLAG_RESTORE, OP_DECODE} obm_op_t;
endpackage

// ===== hw/obm_dec_if.sv
// Carrier between the byte-move core and its operand decoder
`timescale 1ns/10ps
`default_nettype none
interface obm_dec_if;
	obm_pkg::obm_opnd_t opndClass;
	logic [1:0] pairIdx;
	logic [7:0] imm;
	logic [15:0] addrField;
	logic [15:0] pc;
	logic [15:0] hl;
	logic [15:0] de;
	logic [7:0] regB;
	logic [7:0] regC;
	logic [15:0] effAddr;
	logic fault;
	logic inHsRam;
	logic [2:0] pairLoIdx;
	logic [2:0] pairHiIdx;
	logic [7:0] bitMask;
	modport dec (input opndClass, pairIdx, imm, addrField, pc, hl, de, regB, regC,
		output effAddr, fault, inHsRam, pairLoIdx, pairHiIdx, bitMask);
	modport core (output opndClass, pairIdx, imm, addrField, pc, hl, de, regB, regC,
		input effAddr, fault, inHsRam, pairLoIdx, pairHiIdx, bitMask);
endinterface
`default_nettype wire

// ===== hw/obm_operand_decode.sv
// Combinational operand address decoder
`timescale 1ns/10ps
`default_nettype none
module obm_operand_decode (
	obm_dec_if.dec bus
);
	// ----------------------------------------
	// Candidate addresses per operand class
	// ----------------------------------------
	wire logic [15:0] saddrAddr = obm_pkg::SADDR_BASE + {8'h00, bus.addrField[7:0]};
	wire logic [15:0] sfrAddr = obm_pkg::SFR_BASE | {8'h00, bus.addrField[7:0]};
	wire logic [15:0] callAddr = obm_pkg::CALL_BASE | {5'h00, bus.addrField[10:0]};
	wire logic [15:0] vecAddr = obm_pkg::VEC_BASE | {10'h000, bus.addrField[4:0], 1'b0};
	wire logic [15:0] relAddr = bus.pc + {{8{bus.imm[7]}}, bus.imm};
	wire logic [15:0] hlByteAddr = bus.hl + {8'h00, bus.imm};
	wire logic [15:0] hlBAddr = bus.hl + {8'h00, bus.regB};
	wire logic [15:0] hlCAddr = bus.hl + {8'h00, bus.regC};
	// Hole in the special register space is refused for both sfr operand forms
	wire logic sfrHole = (sfrAddr >= obm_pkg::SFR_HOLE_LO) && (sfrAddr <= obm_pkg::SFR_HOLE_HI);
	logic [15:0] addrSel;
	logic faultSel;

	// Address selection and alignment checks
	always_comb begin
		addrSel = 16'h0000;
		faultSel = 1'b0;
		case (bus.opndClass)
			obm_pkg::OPND_SADDR: addrSel = saddrAddr;
			obm_pkg::OPND_SADDRP: begin
				addrSel = saddrAddr;
				faultSel = saddrAddr[0];
			end
			obm_pkg::OPND_SFR: begin
				addrSel = sfrAddr;
				faultSel = sfrHole;
			end
			obm_pkg::OPND_SFRP: begin
				addrSel = sfrAddr;
				faultSel = sfrHole | sfrAddr[0];
			end
			obm_pkg::OPND_ABS: addrSel = bus.addrField;
			obm_pkg::OPND_ABSW: begin
				addrSel = bus.addrField;
				faultSel = bus.addrField[0];
			end
			obm_pkg::OPND_DE: addrSel = bus.de;
			obm_pkg::OPND_HL: addrSel = bus.hl;
			obm_pkg::OPND_HLBYTE: addrSel = hlByteAddr;
			obm_pkg::OPND_HLB: addrSel = hlBAddr;
			obm_pkg::OPND_HLC: addrSel = hlCAddr;
			obm_pkg::OPND_CALL: addrSel = callAddr;
			obm_pkg::OPND_VEC: addrSel = vecAddr;
			obm_pkg::OPND_REL: addrSel = relAddr;
			default: addrSel = 16'h0000;
		endcase
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign bus.effAddr = addrSel;
	assign bus.fault = faultSel;
	assign bus.inHsRam = (addrSel >= obm_pkg::HSRAM_LO) && (addrSel <= obm_pkg::HSRAM_HI);
	assign bus.pairLoIdx = {bus.pairIdx, 1'b0};
	assign bus.pairHiIdx = {bus.pairIdx, 1'b1};
	assign bus.bitMask = 8'h01 << bus.imm[2:0];
endmodule // obm_operand_decode
`default_nettype wire

// ===== sim/obm_mem_model.sv
// Behavioural internal memory answering the core's byte bus
`timescale 1ns/10ps
`default_nettype none
module obm_mem_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic memReq,
	input wire logic memWe,
	input wire logic [15:0] memAddr,
	input wire logic [7:0] memWdata,
	input wire logic [3:0] lat,
	output logic [7:0] memRdata,
	output logic memRvalid
);
	logic [7:0] mem [0:65535];
	logic pend;
	logic [3:0] cnt;
	logic [15:0] hold;
	// Known contents so the bench can predict every read
	initial begin
		for (int a = 0; a < 65536; a++) mem[a] = 8'(a) ^ 8'h5A;
	end
	// Idle data toggles so a stale read never looks right
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend <= 1'b0;
			cnt <= 4'h0;
			hold <= 16'h0000;
			memRvalid <= 1'b0;
			memRdata <= 8'hA5;
		end else begin
			memRvalid <= 1'b0;
			memRdata <= ~memRdata;
			if (memReq && memWe) mem[memAddr] <= memWdata;
			if (memReq && !memWe) begin
				pend <= 1'b1;
				cnt <= lat;
				hold <= memAddr;
			end else if (pend && cnt == 4'h0) begin
				pend <= 1'b0;
				memRvalid <= 1'b1;
				memRdata <= mem[hold];
			end else if (pend) cnt <= cnt - 4'h1;
		end
	end
endmodule // obm_mem_model
`default_nettype wire

// ===== sim/obm_core_asserts.sv
// Port-level checker for the byte-move core
`timescale 1ns/10ps
`default_nettype none
module obm_core_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic instBusy,
	input wire logic instDone,
	input wire logic operandFault,
	input wire logic [5:0] instClocks,
	input wire logic [7:0] bitMask,
	input wire logic memReq,
	input wire logic memWe,
	input wire logic [15:0] memAddr
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_done_one_pulse: assert property (instDone |=> !instDone) else $error("done too long");
	a_done_not_busy: assert property (instDone |-> !instBusy) else $error("busy at done");
	a_busy_ends_done: assert property ($fell(instBusy) |-> instDone) else $error("busy fell early");
	a_busy_bounded: assert property ($rose(instBusy) |-> ##[1:200] instDone) else $error("no done");
	a_fault_zero_clocks: assert property (instDone && operandFault |-> instClocks == 6'h00)
		else $error("fault counted");
	a_mask_one_hot: assert property (instDone |-> $onehot(bitMask))
		else $error("mask not one-hot");
	a_req_in_busy: assert property (memReq |-> instBusy) else $error("req outside instr");
	a_req_one_cycle: assert property (memReq |=> !memReq || memWe) else $error("read req held");
	a_addr_held: assert property (!memReq |-> $stable(memAddr) && $stable(memWe))
		else $error("addr moved");
	c_fault: cover property (instDone && operandFault);
	c_write: cover property (memReq && memWe);
	c_read: cover property (memReq && !memWe);
endmodule // obm_core_asserts
bind obm_byte_move_core obm_core_asserts i_chk (.clk(clk), .rst_n(rst_n), .instBusy(instBusy),
	.instDone(instDone), .operandFault(operandFault), .instClocks(instClocks),
	.bitMask(bitMask), .memReq(memReq), .memWe(memWe), .memAddr(memAddr));
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the byte-move core
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk = 1'b0, rst_n = 1'b0, instValid = 1'b0, rom = 1'b1, rz = 1'b0, rh = 1'b0, rc = 1'b0;
	obm_pkg::obm_op_t instOp = obm_pkg::OP_DECODE;
	obm_pkg::obm_opnd_t opnd = obm_pkg::OPND_NONE;
	logic [2:0] instReg = 3'h0, processor_clock_ctrl = 3'h0;
	logic [7:0] imm = 8'h00, saved = 8'h00, rdata, acc, program_status_word, bitMask, wdata;
	logic [15:0] addr = 16'h0000, pc = 16'h0000, dAddr, mAddr;
	logic [5:0] clks;
	logic [3:0] lat = 4'h0;
	logic busy, done, fault, rvalid, req, we;
	int fails = 0, tests_run = 0, cyc, c0;
	always #5 clk = ~clk;
	obm_byte_move_core i_dut (.clk(clk), .rst_n(rst_n), .instValid(instValid), .instOp(instOp),
		.instOperand(opnd), .instReg(instReg), .instPair(2'h0), .instImm(imm), .instAddr(addr),
		.instPc(pc), .fetchFromRom(rom), .resZero(rz), .resHalfCarry(rh), .resCarry(rc),
		.savedPsw(saved), .processorClockCtrl(processor_clock_ctrl), .memRdata(rdata), .memRvalid(rvalid),
		.instBusy(busy), .instDone(done), .operandFault(fault), .decodedAddr(dAddr),
		.bitMask(bitMask), .instClocks(clks), .accumulator(acc), .programStatusWord(program_status_word),
		.memReq(req), .memWe(we), .memAddr(mAddr), .memWdata(wdata));
	obm_mem_model i_mem (.clk(clk), .rst_n(rst_n), .memReq(req), .memWe(we), .memAddr(mAddr),
		.memWdata(wdata), .lat(lat), .memRdata(rdata), .memRvalid(rvalid));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
			fails++;
		end
	endtask
	// One instruction, timed from take to done in cycles
	task automatic run(input obm_pkg::obm_op_t op, input obm_pkg::obm_opnd_t od,
		input logic [2:0] r, input logic [7:0] im, input logic [15:0] ad);
		@(negedge clk);
		instOp = op;
		opnd = od;
		instReg = r;
		imm = im;
		addr = ad;
		instValid = 1'b1;
		@(negedge clk);
		instValid = 1'b0;
		cyc = 1;
		while (done !== 1'b1 && cyc < 300) begin
			@(negedge clk);
			cyc++;
		end
		if (cyc >= 300) fails++;
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		fails++;
		wrap_up();
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		chk({8'h00, program_status_word}, 16'h0002);
		chk({8'h00, acc}, 16'h0000);
		for (int i = 0; i < 8; i++) run(obm_pkg::OP_MOV_R_IMM, obm_pkg::OPND_REG, 3'(i), 8'h10 + 8'(i), 16'h0000);
		chk({10'h000, clks}, {10'h000, obm_pkg::CLK_R_IMM});
		for (int i = 0; i < 8; i++) begin
			run(obm_pkg::OP_MOV_A_R, obm_pkg::OPND_REG, 3'(i), 8'h00, 16'h0000);
			chk({8'h00, acc}, (i == 1) ? 16'h0010 : 16'h0010 + 16'(i));
			chk({10'h000, clks}, {10'h000, obm_pkg::CLK_REG});
		end
		// Slow memory; exchange at top of window, then read back old A
		lat = 4'h3;
		run(obm_pkg::OP_XCH_A_M, obm_pkg::OPND_SADDR, 3'h0, 8'h00, 16'h00FF);
		chk(dAddr, 16'hFF1F);
		chk({8'h00, acc}, 16'h0045);
		chk({10'h000, clks}, {10'h000, obm_pkg::CLK_SADDR + 6'h02});
		chk({8'h00, program_status_word}, 16'h0002);
		lat = 4'h0;
		run(obm_pkg::OP_MOV_A_M, obm_pkg::OPND_SADDR, 3'h0, 8'h00, 16'h00FF);
		chk({8'h00, acc}, 16'h0017);
		chk({10'h000, clks}, {10'h000, obm_pkg::CLK_SADDR + 6'h01});
		run(obm_pkg::OP_MOV_A_M, obm_pkg::OPND_SADDR, 3'h0, 8'h00, 16'h0000);
		chk({dAddr, acc, 2'h0, clks}, {16'hFE20, 8'h7A, 2'h0, obm_pkg::CLK_SADDR});
		rom = 1'b0;
		run(obm_pkg::OP_MOV_A_M, obm_pkg::OPND_ABS, 3'h0, 8'h00, 16'h1234);
		rom = 1'b1;
		chk({dAddr, acc}, {16'h1234, 8'h6E});
		chk({10'h000, clks}, {10'h000, obm_pkg::CLK_ABS + 6'h01 + obm_pkg::FETCH_EXTRA});
		// Pure decode of call, table, relative and bit operands
		run(obm_pkg::OP_DECODE, obm_pkg::OPND_CALL, 3'h0, 8'h00, 16'h07FF);
		chk(dAddr, 16'h0FFF);
		run(obm_pkg::OP_DECODE, obm_pkg::OPND_CALL, 3'h0, 8'h00, 16'h0000);
		chk(dAddr, 16'h0800);
		run(obm_pkg::OP_DECODE, obm_pkg::OPND_VEC, 3'h0, 8'h00, 16'h001F);
		chk(dAddr, 16'h007E);
		pc = 16'h1000;
		run(obm_pkg::OP_DECODE, obm_pkg::OPND_REL, 3'h0, 8'h80, 16'h0000);
		chk(dAddr, 16'h0F80);
		for (int i = 0; i < 8; i++) begin
			run(obm_pkg::OP_DECODE, obm_pkg::OPND_BIT, 3'h0, 8'hF8 | 8'(i), 16'h0000);
			chk({8'h00, bitMask}, 16'h0001 << i);
		end
		// Refused operands: hole, odd word addresses; then a legal special one
		run(obm_pkg::OP_MOV_A_M, obm_pkg::OPND_SFR, 3'h0, 8'h00, 16'h00D5);
		chk({15'h0000, fault}, 16'h0001);
		chk({8'h00, acc}, 16'h006E);
		run(obm_pkg::OP_DECODE, obm_pkg::OPND_SFRP, 3'h0, 8'h00, 16'h0021);
		chk({15'h0000, fault}, 16'h0001);
		run(obm_pkg::OP_DECODE, obm_pkg::OPND_SADDRP, 3'h0, 8'h00, 16'h0011);
		chk({15'h0000, fault}, 16'h0001);
		run(obm_pkg::OP_DECODE, obm_pkg::OPND_ABSW, 3'h0, 8'h00, 16'h4001);
		chk({15'h0000, fault}, 16'h0001);
		run(obm_pkg::OP_DECODE, obm_pkg::OPND_SFR, 3'h0, 8'h00, 16'h0010);
		chk({fault, dAddr[14:0]}, 16'h7F10);
		// Stores through the pointer pair and a short direct immediate
		run(obm_pkg::OP_MOV_M_A, obm_pkg::OPND_HL, 3'h0, 8'h00, 16'h0000);
		chk({mAddr, wdata, 2'h0, clks}, {16'h1716, 8'h6E, 2'h0, obm_pkg::CLK_IND + 6'h01});
		run(obm_pkg::OP_XCH_A_R, obm_pkg::OPND_REG, 3'h2, 8'h00, 16'h0000);
		chk({8'h00, acc}, 16'h0012);
		run(obm_pkg::OP_MOV_A_M, obm_pkg::OPND_HL, 3'h0, 8'h00, 16'h0000);
		chk({8'h00, acc}, 16'h006E);
		run(obm_pkg::OP_MOV_M_IMM, obm_pkg::OPND_SADDR, 3'h0, 8'hC3, 16'h0080);
		chk({mAddr, wdata, 2'h0, clks}, {16'hFEA0, 8'hC3, 2'h0, obm_pkg::CLK_SADDR_IMM});
		// Flag updates from result, restore and status moves
		{rz, rh, rc} = 3'b111;
		run(obm_pkg::OP_FLAG_RESULT, obm_pkg::OPND_NONE, 3'h0, 8'h00, 16'h0000);
		chk({8'h00, program_status_word}, 16'h0053);
		{rz, rh, rc} = 3'b010;
		run(obm_pkg::OP_FLAG_RESULT, obm_pkg::OPND_NONE, 3'h0, 8'h00, 16'h0000);
		chk({8'h00, program_status_word}, 16'h0012);
		saved = 8'h43;
		run(obm_pkg::OP_FLAG_RESTORE, obm_pkg::OPND_NONE, 3'h0, 8'h00, 16'h0000);
		chk({8'h00, program_status_word}, 16'h0043);
		run(obm_pkg::OP_MOV_PSW_IMM, obm_pkg::OPND_NONE, 3'h0, 8'h51, 16'h0000);
		run(obm_pkg::OP_MOV_A_PSW, obm_pkg::OPND_NONE, 3'h0, 8'h00, 16'h0000);
		chk({program_status_word, acc}, 16'h5151);
		// Slower CPU clock stretches each instruction clock
		run(obm_pkg::OP_MOV_A_R, obm_pkg::OPND_REG, 3'h2, 8'h00, 16'h0000);
		c0 = cyc;
		@(negedge clk);
		processor_clock_ctrl = 3'h2;
		run(obm_pkg::OP_MOV_A_R, obm_pkg::OPND_REG, 3'h2, 8'h00, 16'h0000);
		chk(16'(cyc - c0), 16'h0006);
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
